// ==== hdl/cbgl_glue.sv ====
// Purpose: CPU board glue: bus buffers, slot sense, line-sync interrupt,
//          reset fan-out, activity lamp and memory strobes, plus an
//          AHB-Lite status and control port.
// Assumes: All board pins are asynchronous to hclk and pass two flops.
// Notes: Every output is registered, so pin-to-pin delay is three clocks.
//
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module cbgl_glue #(
    parameter int EDGE_CNT_W = 16
) (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Processor side pins.
    input wire logic [cbgl_pkg::PROC_ADDR_W-1:0] proc_addr,
    input wire logic proc_rw,
    input wire logic data_buffer_enable_n,
    input wire logic data_output_enable_n,
    input wire logic boot_rom_select_n,
    input wire logic sram_select_n,
    input wire logic main_ram_select_n,
    input wire logic byte0_write_n,
    input wire logic byte1_write_n,
    input wire logic byte2_write_n,
    input wire logic byte3_write_n,
    input wire logic processor_reset_out,
    input wire logic activity_led_ctl,
    input wire logic sync_latch_clear_n,
    // Backplane and supply pins.
    input wire logic slot_a_present_n,
    input wire logic slot_b_present_n,
    input wire logic line_sync,
    input wire logic supply_power_good,
    // Buffer controls.
    output logic xcvr_enable_n,
    output logic xcvr_dir,
    output logic [cbgl_pkg::BOARD_ADDR_W-1:0] board_addr,
    output logic [cbgl_pkg::BOARD_ADDR_W-1:0] ram_addr,
    // Slot sense and serial driver enables.
    output logic slot_a_present,
    output logic slot_b_present,
    output logic serial_port_one_tx_en,
    output logic serial_port_two_tx_en,
    output logic serial_port_five_tx_en,
    // Interrupt, resets and lamp.
    output logic sync_irq_n,
    output logic backplane_reset_out,
    output logic external_reset_out,
    output logic front_panel_led_line,
    // Memory strobes.
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic sram_ce_n,
    output logic sram_oe_n,
    output logic sram_rw_n,
    output logic low_byte_en_n,
    output logic high_byte_en_n,
    output logic ram_ce_n,
    output logic ram_oe_n,
    output logic ram_we_n,
    output logic ram_lo_lb_n,
    output logic ram_lo_ub_n,
    output logic ram_hi_lb_n,
    output logic ram_hi_ub_n
);

    // ==========================================================
    // Elaboration check
    // ==========================================================
    if (EDGE_CNT_W < 1 || EDGE_CNT_W > 32) begin : g_bad_width
        $error("EDGE_CNT_W must lie between 1 and 32");
    end

    // ==========================================================
    // Strobe helpers
    // ==========================================================
    // Read strobe: selected and processor reading (rw high).
    function automatic logic rd_n(input logic sel_n, input logic rw);
        rd_n = sel_n | ~rw;
    endfunction
    // Write strobe: selected and processor writing (rw low).
    function automatic logic wr_n(input logic sel_n, input logic rw);
        wr_n = sel_n | rw;
    endfunction
    // Byte lane enable: every lane on a read, only strobed lanes on a write.
    function automatic logic lane_n(input logic sel_n, input logic rw, input logic wstb_n);
        lane_n = rw ? sel_n : (sel_n | wstb_n);
    endfunction

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    localparam int PIN_W = cbgl_pkg::PROC_ADDR_W + 17;
    // The line-sync bit idles low, so a line held low at release shows no edge.
    localparam int LINE_BIT = 1;
    localparam logic [PIN_W-1:0] PIN_IDLE = ~(PIN_W'(1) << LINE_BIT);
    logic [PIN_W-1:0] pin_raw, pin_s1, pin_s2, next_pin_s1, next_pin_s2;
    logic [cbgl_pkg::PROC_ADDR_W-1:0] s_addr;
    logic s_rw, s_dbe_n, s_doe_n, s_boot_n, s_sram_n, s_ram_n;
    logic s_b0_n, s_b1_n, s_b2_n, s_b3_n, s_prst, s_led, s_clr_n;
    logic s_slot_a_n, s_slot_b_n, s_line, s_pgood;

    // Gather pins so one pair of flops covers them all.
    assign pin_raw = {proc_addr, proc_rw, data_buffer_enable_n, data_output_enable_n,
                      boot_rom_select_n, sram_select_n, main_ram_select_n,
                      byte0_write_n, byte1_write_n, byte2_write_n, byte3_write_n,
                      processor_reset_out, activity_led_ctl, sync_latch_clear_n,
                      slot_a_present_n, slot_b_present_n, line_sync, supply_power_good};
    assign {s_addr, s_rw, s_dbe_n, s_doe_n, s_boot_n, s_sram_n, s_ram_n,
            s_b0_n, s_b1_n, s_b2_n, s_b3_n, s_prst, s_led, s_clr_n,
            s_slot_a_n, s_slot_b_n, s_line, s_pgood} = pin_s2;

    // The first stage feeds only the second, so metastability stays put.
    always_comb begin
        next_pin_s1 = pin_raw;
        next_pin_s2 = pin_s1; // [R24]
    end

    // Idle levels: line sync low, every other pin high, so selects and sense lines are inactive.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
        end else begin
            pin_s1 <= next_pin_s1;
            pin_s2 <= next_pin_s2;
        end
    end

    // ==========================================================
    // Line-sync edge latches
    // ==========================================================
    logic line_prev, next_line_prev, rise_latch, next_rise_latch, fall_latch, next_fall_latch;
    logic [EDGE_CNT_W-1:0] edge_count, next_edge_count;
    logic next_sync_irq_n, rise_evt, fall_evt, clear_req, soft_clear;

    assign rise_evt = s_line & ~line_prev;
    assign fall_evt = ~s_line & line_prev;
    assign clear_req = ~s_clr_n | soft_clear;

    // Clear first, then a fresh edge sets again, so no edge is dropped.
    always_comb begin
        next_line_prev = s_line;
        next_rise_latch = rise_latch;
        next_fall_latch = fall_latch;
        next_edge_count = edge_count;
        if (clear_req) begin
            next_rise_latch = 1'b0; // [R10]
            next_fall_latch = 1'b0; // [R10]
        end
        if (rise_evt) begin
            next_rise_latch = 1'b1; // [R8] [R25]
        end
        if (fall_evt) begin
            next_fall_latch = 1'b1; // [R9] [R25]
        end
        if (rise_evt || fall_evt) begin
            next_edge_count = edge_count + 1'b1;
        end
        next_sync_irq_n = ~(next_rise_latch | next_fall_latch); // [R7]
    end

    // The previous level resets low, so a line already high at release
    // counts as one rising edge.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            line_prev <= 1'b0;
            rise_latch <= 1'b0;
            fall_latch <= 1'b0;
            edge_count <= '0;
            sync_irq_n <= 1'b1;
        end else begin
            line_prev <= next_line_prev;
            rise_latch <= next_rise_latch;
            fall_latch <= next_fall_latch;
            edge_count <= next_edge_count;
            sync_irq_n <= next_sync_irq_n;
        end
    end

    // ==========================================================
    // Board pin outputs
    // ==========================================================
    logic [cbgl_pkg::BOARD_ADDR_W-1:0] next_board_addr, next_ram_addr;
    logic next_xcvr_enable_n, next_xcvr_dir, next_slot_a, next_slot_b, next_sp1, next_sp2;
    logic next_sp5, next_bp_rst, next_ext_rst, next_led, next_flash_ce_n, next_flash_oe_n;
    logic next_flash_we_n, next_sram_ce_n, next_sram_oe_n, next_sram_rw_n, next_lb_n, next_ub_n;
    logic next_ram_ce_n, next_ram_oe_n, next_ram_we_n, next_lo_lb_n, next_lo_ub_n, next_hi_lb_n;
    logic next_hi_ub_n;

    // Pure decode of the synchronised pins; no wait states are inserted.
    always_comb begin
        next_xcvr_enable_n = s_dbe_n; // [R1]
        next_xcvr_dir = s_doe_n; // [R2]
        next_board_addr = s_addr[cbgl_pkg::BOARD_ADDR_W-1:0]; // [R3]
        next_ram_addr = s_addr[cbgl_pkg::RAM_ADDR_LSB +: cbgl_pkg::BOARD_ADDR_W]; // [R19]
        next_slot_a = ~s_slot_a_n; // [R4]
        next_slot_b = ~s_slot_b_n; // [R4]
        next_sp1 = ~s_slot_a_n; // [R5]
        next_sp2 = ~s_slot_a_n; // [R5]
        next_sp5 = ~s_slot_b_n; // [R6]
        next_bp_rst = s_prst; // [R11]
        next_ext_rst = s_prst | ~s_pgood; // [R12]
        next_led = s_led; // [R13]
        next_flash_ce_n = s_boot_n; // [R14]
        next_flash_oe_n = rd_n(s_boot_n, s_rw); // [R15]
        next_flash_we_n = wr_n(s_boot_n, s_rw); // [R15]
        next_sram_ce_n = s_sram_n; // [R14]
        next_sram_oe_n = rd_n(s_sram_n, s_rw); // [R17]
        next_sram_rw_n = wr_n(s_sram_n, s_rw); // [R18]
        next_lb_n = lane_n(s_sram_n, s_rw, s_b0_n); // [R18]
        next_ub_n = lane_n(s_sram_n, s_rw, s_b1_n); // [R18]
        next_ram_ce_n = s_ram_n; // [R14]
        next_ram_oe_n = rd_n(s_ram_n, s_rw); // [R20] [R21]
        next_ram_we_n = wr_n(s_ram_n, s_rw); // [R20] [R21]
        // Lower device carries bytes 0 and 1, upper bytes 2 and 3.
        next_lo_lb_n = lane_n(s_ram_n, s_rw, s_b0_n); // [R22] [R23]
        next_lo_ub_n = lane_n(s_ram_n, s_rw, s_b1_n); // [R22] [R23]
        next_hi_lb_n = lane_n(s_ram_n, s_rw, s_b2_n); // [R22] [R23]
        next_hi_ub_n = lane_n(s_ram_n, s_rw, s_b3_n); // [R22] [R23]
    end

    // Reset leaves every memory deselected and the buffers isolated.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xcvr_enable_n <= 1'b1;
            xcvr_dir <= 1'b1;
            board_addr <= '0;
            ram_addr <= '0;
            slot_a_present <= 1'b0;
            slot_b_present <= 1'b0;
            serial_port_one_tx_en <= 1'b0;
            serial_port_two_tx_en <= 1'b0;
            serial_port_five_tx_en <= 1'b0;
            backplane_reset_out <= 1'b1;
            external_reset_out <= 1'b1;
            front_panel_led_line <= 1'b0;
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            sram_ce_n <= 1'b1;
            sram_oe_n <= 1'b1;
            sram_rw_n <= 1'b1;
            low_byte_en_n <= 1'b1;
            high_byte_en_n <= 1'b1;
            ram_ce_n <= 1'b1;
            ram_oe_n <= 1'b1;
            ram_we_n <= 1'b1;
            ram_lo_lb_n <= 1'b1;
            ram_lo_ub_n <= 1'b1;
            ram_hi_lb_n <= 1'b1;
            ram_hi_ub_n <= 1'b1;
        end else begin
            xcvr_enable_n <= next_xcvr_enable_n;
            xcvr_dir <= next_xcvr_dir;
            board_addr <= next_board_addr;
            ram_addr <= next_ram_addr;
            slot_a_present <= next_slot_a;
            slot_b_present <= next_slot_b;
            serial_port_one_tx_en <= next_sp1;
            serial_port_two_tx_en <= next_sp2;
            serial_port_five_tx_en <= next_sp5;
            backplane_reset_out <= next_bp_rst;
            external_reset_out <= next_ext_rst;
            front_panel_led_line <= next_led;
            flash_ce_n <= next_flash_ce_n;
            flash_oe_n <= next_flash_oe_n;
            flash_we_n <= next_flash_we_n;
            sram_ce_n <= next_sram_ce_n;
            sram_oe_n <= next_sram_oe_n;
            sram_rw_n <= next_sram_rw_n;
            low_byte_en_n <= next_lb_n;
            high_byte_en_n <= next_ub_n;
            ram_ce_n <= next_ram_ce_n;
            ram_oe_n <= next_ram_oe_n;
            ram_we_n <= next_ram_we_n;
            ram_lo_lb_n <= next_lo_lb_n;
            ram_lo_ub_n <= next_lo_ub_n;
            ram_hi_lb_n <= next_hi_lb_n;
            ram_hi_ub_n <= next_hi_ub_n;
        end
    end

    // ==========================================================
    // AHB-Lite slave
    // ==========================================================
    logic dp_write, next_dp_write, take;
    logic [cbgl_pkg::REG_OFS_W-1:0] dp_ofs, next_dp_ofs;
    logic [31:0] next_hrdata, status_word;

    assign take = hsel & hready & htrans[cbgl_pkg::HTRANS_ACTIVE_BIT];
    // A write of one to the clear bit acts in its own data phase.
    assign soft_clear = dp_write && dp_ofs == cbgl_pkg::REG_CTRL
                        && hwdata[cbgl_pkg::CTRL_SOFT_CLEAR]; // [R10]

    // Status gathers the latches and the sensed pin levels.
    always_comb begin
        status_word = cbgl_pkg::RDATA_IDLE;
        status_word[cbgl_pkg::ST_RISE] = rise_latch;
        status_word[cbgl_pkg::ST_FALL] = fall_latch;
        status_word[cbgl_pkg::ST_SLOT_A] = slot_a_present;
        status_word[cbgl_pkg::ST_SLOT_B] = slot_b_present;
        status_word[cbgl_pkg::ST_POWER_GOOD] = s_pgood;
        status_word[cbgl_pkg::ST_LINE_LEVEL] = s_line;
    end

    // Read data is fetched in the address phase so the slave never waits;
    // the price is that it shows state as of that edge.
    always_comb begin
        next_dp_write = take & hwrite;
        next_dp_ofs = haddr[cbgl_pkg::REG_OFS_W-1:0];
        next_hrdata = cbgl_pkg::RDATA_IDLE;
        if (take && !hwrite) begin
            case (haddr[cbgl_pkg::REG_OFS_W-1:0])
                cbgl_pkg::REG_STATUS: next_hrdata = status_word;
                cbgl_pkg::REG_EDGES: next_hrdata = 32'(edge_count);
                default: next_hrdata = cbgl_pkg::RDATA_IDLE;
            endcase
        end
    end

    // The slave is always ready and always answers OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_ofs <= '0;
            hrdata <= cbgl_pkg::RDATA_IDLE;
            hreadyout <= 1'b1;
            hresp <= cbgl_pkg::HRESP_OKAY;
        end else begin
            dp_write <= next_dp_write;
            dp_ofs <= next_dp_ofs;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= cbgl_pkg::HRESP_OKAY;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    logic [1:0] warm;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warm <= 2'h0;
        end else if (warm != 2'h3) begin
            warm <= warm + 2'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_rise_sets_irq: assert property (rise_evt |=> rise_latch && !sync_irq_n) // [R8]
        else $error("rising edge did not raise the request");
    a_fall_sets_irq: assert property (fall_evt |=> fall_latch && !sync_irq_n) // [R9]
        else $error("falling edge did not raise the request");
    a_irq_tracks_latch: assert property (##1 sync_irq_n == !(rise_latch || fall_latch)) // [R7]
        else $error("request level disagrees with edge latches");
    a_clear_releases: assert property (clear_req && !rise_evt && !fall_evt
        |=> !rise_latch && !fall_latch && sync_irq_n) // [R10]
        else $error("clear did not release the request");
    a_edge_beats_clear: assert property (clear_req && rise_evt |=> rise_latch ##1 1'b1) // [R25]
        else $error("edge lost against a clear");
    a_slot_gates: assert property (warm == 2'h3 |-> serial_port_one_tx_en
        == $past(!slot_a_present_n, 3) && serial_port_five_tx_en
        == $past(!slot_b_present_n, 3)) // [R5] [R6]
        else $error("serial driver enable disagrees with slot sense");
    a_ext_reset_mix: assert property (warm == 2'h3 |-> external_reset_out
        == $past(processor_reset_out || !supply_power_good, 3)) // [R12]
        else $error("external reset is not the documented combination");
    a_flash_strobes: assert property (warm == 2'h3 |-> flash_oe_n
        == $past(boot_rom_select_n || !proc_rw, 3)) // [R15]
        else $error("flash read strobe wrong");
    a_ram_write_mode: assert property (!ram_we_n |-> !ram_ce_n && ram_oe_n) // [R21]
        else $error("main RAM write with output enable low");
    a_buffer_ctl: assert property (warm == 2'h3 |-> xcvr_enable_n
        == $past(data_buffer_enable_n, 3) && xcvr_dir == $past(data_output_enable_n, 3)) // [R1]
        else $error("transceiver control does not follow its pins");
    c_rise: cover property (rise_evt ##1 !sync_irq_n);
    c_fall: cover property (fall_evt ##1 !sync_irq_n);
    c_clear_with_edge: cover property (clear_req && (rise_evt || fall_evt));
    c_status_read: cover property (take && !hwrite && haddr[7:0] == cbgl_pkg::REG_STATUS);

endmodule

`default_nettype wire

// ==== hdl/cbgl_pkg.sv ====
// Purpose: Shared constants for the CPU board glue logic.
// Assumes: One 20 MHz clock (hclk); every board pin is asynchronous to it.
// Notes: Contract
// Contract
// (R1) Transceivers connect only while buffer enable low.
// (R2) Transceiver direction follows data output enable.
// (R3) Address path always driven, never gated.
// (R4) Presence output high when sense line grounded.
// (R5) Serial ports one, two need slot A.
// (R6) Serial port five needs slot B.
// (R7) Interrupt request on both line-sync edges.
// (R8) Rising edge sets rising latch, holds request.
// (R9) Falling edge sets falling latch, holds request.
// (R10) Clear pulse idles both latches, releases request.
// (R11) Backplane reset equals processor reset level.
// (R12) External reset: processor reset or power not good.
// (R13) Activity control drives front panel lamp line.
// (R14) Each memory: own select, zero wait states.
// (R15) Flash read uses oe, write uses we.
// (R16) Software splits flash: application plus boot image.
// (R17) Battery SRAM read: enable and oe low.
// (R18) SRAM write: rw low, byte enables pick bytes.
// (R19) Main RAM addressed by processor bits two up.
// (R20) RAM read: ce, oe low, we high.
// (R21) RAM write: ce, we low, oe high.
// (R22) Lower RAM bits 0-15, upper 16-31.
// (R23) Four byte strobes drive four byte enables.
// (R24) Line sync passes two flops before edges.
// (R25) Edge in clear cycle wins over clear.

package cbgl_pkg;

    // ==========================================================
    // Address widths
    // ==========================================================
    localparam int PROC_ADDR_W = 25;
    localparam int BOARD_ADDR_W = 23;
    localparam int RAM_ADDR_LSB = 2;

    // ==========================================================
    // Register map, word aligned byte offsets
    // ==========================================================
    localparam int REG_OFS_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_EDGES = 8'h08;
    localparam int CTRL_SOFT_CLEAR = 0;
    localparam int ST_RISE = 0;
    localparam int ST_FALL = 1;
    localparam int ST_SLOT_A = 2;
    localparam int ST_SLOT_B = 3;
    localparam int ST_POWER_GOOD = 4;
    localparam int ST_LINE_LEVEL = 5;

    // ==========================================================
    // Bus encodings
    // ==========================================================
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [31:0] RDATA_IDLE = 32'h00000000;
endpackage

// ==== dv/cbgl_proc_model.sv ====
// Purpose: Processor side of the line-sync interrupt handshake.
// Assumes: The glue samples the clear line on hclk, so one low cycle is a pulse.
// Notes: ack_delay sets how slowly the processor answers; ack_en low never answers.
`timescale 1ns/100ps
`default_nettype none

module cbgl_proc_model (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Bench control.
    input wire logic ack_en,
    input wire logic [3:0] ack_delay,
    // Interrupt handshake.
    input wire logic sync_irq_n,
    output logic sync_latch_clear_n
);
    logic [4:0] wait_cnt;

    // The count stops past the delay, so one request gives one pulse even
    // while the release is still on its way back through the glue.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 5'h00;
            sync_latch_clear_n <= 1'b1;
        end else begin
            sync_latch_clear_n <= !(ack_en && !sync_irq_n && wait_cnt == {1'b0, ack_delay});
            if (!ack_en || sync_irq_n) begin
                wait_cnt <= 5'h00;
            end else if (wait_cnt <= {1'b0, ack_delay}) begin
                wait_cnt <= wait_cnt + 5'h01;
            end
        end
    end
endmodule

`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the CPU board glue logic.
// Assumes: Pin outputs follow their pins three clocks later; the bus never waits.
// Notes: Pin cases run from a table; line-sync and bus cases follow by hand.
`timescale 1ns/100ps
`default_nettype none

module testbench;
    // ==========================================
    // Stimulus table and signals
    // ==========================================
    typedef struct packed {
        logic [14:0] pin;
        logic [24:0] exp;
    } cbgl_row_s;
    // Pins: flash, sram, ram selects, rw, byte3..0, slot a, slot b, reset, power, lamp, buf, dir.
    cbgl_row_s rows [6] = '{'{15'h3F8C, 25'h07FFFE4}, '{15'h37FB, 25'h0BFFC1B},
        '{15'h5721, 25'h1D3FEC9}, '{15'h64D6, 25'h1FEA53E}, '{15'h6809, 25'h1FE43E1},
        '{15'h5FEA, 25'h1C9FC02}};
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h00000000;
    logic [31:0] hwdata = 32'h00000000;
    logic [14:0] pins = 15'h7FEB;
    logic [24:0] proc_addr = 25'h0000000;
    logic line_sync = 1'b0;
    logic ack_en = 1'b0;
    logic [3:0] ack_delay = 4'h3;
    logic [31:0] smp_rd, rd;
    logic smp_rdy;
    wire hreadyout, hresp, sync_irq_n, clr_n;
    wire [31:0] hrdata;
    wire [24:0] obs;
    wire [22:0] board_addr, ram_addr;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;

    cbgl_glue dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .proc_addr(proc_addr),
        .proc_rw(pins[11]), .data_buffer_enable_n(pins[1]), .data_output_enable_n(pins[0]),
        .boot_rom_select_n(pins[14]), .sram_select_n(pins[13]), .main_ram_select_n(pins[12]),
        .byte0_write_n(pins[7]), .byte1_write_n(pins[8]), .byte2_write_n(pins[9]),
        .byte3_write_n(pins[10]), .processor_reset_out(pins[4]), .activity_led_ctl(pins[2]),
        .sync_latch_clear_n(clr_n), .slot_a_present_n(pins[6]), .slot_b_present_n(pins[5]),
        .line_sync(line_sync), .supply_power_good(pins[3]), .xcvr_enable_n(obs[1]),
        .xcvr_dir(obs[0]), .board_addr(board_addr), .ram_addr(ram_addr),
        .slot_a_present(obs[9]), .slot_b_present(obs[8]), .serial_port_one_tx_en(obs[7]),
        .serial_port_two_tx_en(obs[6]), .serial_port_five_tx_en(obs[5]),
        .sync_irq_n(sync_irq_n), .backplane_reset_out(obs[4]), .external_reset_out(obs[3]),
        .front_panel_led_line(obs[2]), .flash_ce_n(obs[24]), .flash_oe_n(obs[23]),
        .flash_we_n(obs[22]), .sram_ce_n(obs[21]), .sram_oe_n(obs[20]), .sram_rw_n(obs[19]),
        .low_byte_en_n(obs[18]), .high_byte_en_n(obs[17]), .ram_ce_n(obs[16]),
        .ram_oe_n(obs[15]), .ram_we_n(obs[14]), .ram_lo_lb_n(obs[13]), .ram_lo_ub_n(obs[12]),
        .ram_hi_lb_n(obs[11]), .ram_hi_ub_n(obs[10])
    );

    cbgl_proc_model proc (.hclk(hclk), .hresetn(hresetn), .ack_en(ack_en),
        .ack_delay(ack_delay), .sync_irq_n(sync_irq_n), .sync_latch_clear_n(clr_n));

    // Clock, edge samples of the bus answer, and the hang limit.
    always #25 hclk = ~hclk;
    always @(posedge hclk) begin
        smp_rd <= hrdata;
        smp_rdy <= hreadyout;
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_count++;
            $display("[FAIL] %0t run did not finish", $time);
            summarize();
        end
    end

    // ==========================================
    // Tasks
    // ==========================================
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One single word transfer; the edge samples keep read data race free.
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do begin @(posedge hclk); #1; end while (smp_rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do begin @(posedge hclk); #1; end while (smp_rdy !== 1'b1);
        rd = smp_rd;
    endtask

    // Moves the line with no acknowledge, then checks request and latch flags.
    task sync_step(input logic lvl, input logic [2:0] st);
        @(posedge hclk);
        line_sync <= lvl;
        repeat (5) @(posedge hclk);
        #1;
        chk(32'(sync_irq_n), 32'h0, "irq set");
        ahb(1'b0, 32'(cbgl_pkg::REG_STATUS), 32'h0);
        chk(32'({rd[cbgl_pkg::ST_LINE_LEVEL], rd[cbgl_pkg::ST_FALL], rd[cbgl_pkg::ST_RISE]}),
            32'(st), "status");
    endtask

    task wait_irq(input logic lvl);
        int k;
        for (k = 0; k < 20 && sync_irq_n !== lvl; k++) begin @(posedge hclk); #1; end
        chk(32'(sync_irq_n), 32'(lvl), "irq level");
    endtask

    task summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        repeat (2) @(posedge hclk);
        #1;
        chk(32'({hreadyout, hresp, sync_irq_n, obs[24], obs[16]}), 32'h17, "reset");
        @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            @(posedge hclk);
            pins <= rows[i].pin;
            proc_addr <= 25'h1A5C3E7 ^ (25'h0000001 << i);
            repeat (4) @(posedge hclk);
            #1;
            chk(32'(obs[24:17]), 32'(rows[i].exp[24:17]), "rom");
            chk(32'(obs[16:10]), 32'(rows[i].exp[16:10]), "ram");
            chk(32'(obs[9:5]), 32'(rows[i].exp[9:5]), "slots");
            chk(32'(obs[4:0]), 32'(rows[i].exp[4:0]), "misc");
            chk(32'(board_addr), 32'(proc_addr[22:0]), "board addr");
            chk(32'(ram_addr), 32'(proc_addr[24:2]), "ram addr");
        end
        // Latches with no processor answer, then a clear from the bus.
        sync_step(1'b1, 3'h5);
        ahb(1'b1, 32'(cbgl_pkg::REG_CTRL), 32'h00000001);
        repeat (3) @(posedge hclk);
        #1;
        chk(32'(sync_irq_n), 32'h1, "soft clear");
        sync_step(1'b0, 3'h2);
        // A rising edge seen in the same cycle as a bus clear must survive it.
        line_sync <= 1'b1;
        @(posedge hclk);
        #1;
        ahb(1'b1, 32'(cbgl_pkg::REG_CTRL), 32'h00000001);
        repeat (2) @(posedge hclk);
        #1;
        chk(32'(sync_irq_n), 32'h0, "edge beats clear");
        // Slow and then prompt processor acknowledge.
        ack_en <= 1'b1;
        wait_irq(1'b1);
        ack_delay <= 4'h0;
        line_sync <= 1'b0;
        wait_irq(1'b0);
        wait_irq(1'b1);
        line_sync <= 1'b1;
        wait_irq(1'b0);
        wait_irq(1'b1);
        ahb(1'b0, 32'(cbgl_pkg::REG_EDGES), 32'h0);
        chk(rd, 32'h00000005, "edge count");
        // Unmapped word ignores writes and reads zero; control reads zero in bits 31:1 and answers OKAY.
        ahb(1'b1, 32'h0000000C, 32'hFFFFFFFF);
        ahb(1'b0, 32'h0000000C, 32'h0);
        chk(rd, 32'h00000000, "unmapped");
        ahb(1'b0, 32'(cbgl_pkg::REG_CTRL), 32'h0);
        chk({rd[31:1], hresp}, 32'h00000000, "ctrl read");
        summarize();
    end
endmodule

`default_nettype wire
